/* File: hw/acpc_pkg.sv */
// package: register map, field positions, reset values and carriers for the config bank
package acpc_pkg;

    localparam int          ADDR_W            = 15;
    localparam logic [14:0] OFS_CLOCK_CTRL    = 15'h0029;
    localparam logic [14:0] OFS_SUPPLY_NOISE  = 15'h002B;
    localparam logic [14:0] OFS_SYNC_POS      = 15'h002C;
    localparam logic [14:0] OFS_FULL_SCALE    = 15'h0030;
    localparam logic [14:0] OFS_POWER_MODE    = 15'h0037;
    localparam logic [14:0] OFS_TIMESTAMP     = 15'h003B;
    localparam logic [14:0] OFS_REF_OUT       = 15'h003C;

    localparam logic [7:0]  RST_CLOCK_CTRL    = 8'h80;
    localparam logic [7:0]  RST_SUPPLY_NOISE  = 8'h10;
    localparam logic [15:0] RST_FULL_SCALE    = 16'hA000;
    localparam logic [7:0]  RST_POWER_MODE    = 8'h4B;
    localparam logic [7:0]  RST_TIMESTAMP     = 8'h00;
    localparam logic [7:0]  RST_REF_OUT       = 8'h01;
    localparam logic [23:0] RST_SYNC_POS      = 24'h000000;

    localparam logic [7:0]  MODE_HIGH_PERF    = 8'h4B;
    localparam logic [7:0]  MODE_LOW_POWER    = 8'h46;
    localparam logic [15:0] FS_RECOMMENDED_MIN = 16'h2000;

    localparam int          BIT_CLOCK_QUIET   = 0;
    localparam int          BIT_ANALOG_QUIET  = 2;
    localparam int          BIT_TS_ENABLE     = 0;
    localparam int          BIT_TS_PECL       = 1;
    localparam int          BIT_REF_OUT_EN    = 0;
    localparam int          SYNC_SEL_HI       = 3;

    localparam logic [1:0]  PMODE_HIGH_PERF   = 2'h0;
    localparam logic [1:0]  PMODE_LOW_POWER   = 2'h1;
    localparam logic [1:0]  PMODE_RESERVED    = 2'h2;

    // byte-wide register access carrier
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [14:0] addr;
        logic [7:0]  wdata;
    } acpc_req_s;

    // analog control outputs
    typedef struct packed {
        logic        analog_rail_quiet_enable;
        logic        clock_rail_quiet_enable;
        logic [3:0]  sync_delay_select;
        logic [15:0] full_scale_adjust;
        logic [1:0]  power_mode;
        logic        fs_below_min;
        logic        timestamp_input_enable;
        logic        timestamp_pecl_mode;
    } acpc_ctrl_s;

    typedef enum logic [1:0] {
        ACPC_IDLE,
        ACPC_BUSY
    } acpc_state_e;

endpackage

/* File: hw/acpc_sync_capture.sv */
// capture register holding the sync-reference edge position
`timescale 1ns/1ps
module acpc_sync_capture
    import acpc_pkg::*;
#(
    parameter int POS_W = 24
) (
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    input  wire logic             load,
    input  wire logic [POS_W-1:0] pos_in,
    output logic      [POS_W-1:0] pos_q
);

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pos_q <= POS_W'(RST_SYNC_POS);
        end else if (load) begin
            pos_q <= pos_in;
        end
    end

endmodule

/* File: hw/acpc_regs.sv */
// configuration register bank: supply noise, sync position, full scale, power mode,
// timestamp input and reference clock output
`timescale 1ns/1ps
module acpc_regs
    import acpc_pkg::*;
#(
    parameter int POS_W = 24
) (
    input  wire logic             ref_clk,
    input  wire logic             rst_b,
    input  wire acpc_req_s        req,
    input  wire logic             sync_pos_valid,
    input  wire logic [POS_W-1:0] sync_pos_in,
    input  wire logic             synth_enable,
    output logic      [7:0]       rdata_q,
    output logic                  rvalid_q,
    output acpc_ctrl_s            ctrl_q,
    output logic                  ref_clock_output_q
);

    // ************************************************************
    // reset release and input synchronisers
    // ************************************************************
    logic [1:0] rst_sync_q;
    logic       rst_n;
    logic       synth_meta_q;
    logic       synth_q;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            synth_meta_q <= 1'b0;
            synth_q      <= 1'b0;
        end else begin
            synth_meta_q <= synth_enable;
            synth_q      <= synth_meta_q;
        end
    end

    // ************************************************************
    // register storage
    // ************************************************************
    logic [7:0]       clock_ctrl_q;
    logic [7:0]       supply_noise_q;
    logic [15:0]      full_scale_q;
    logic [7:0]       power_mode_code_q;
    logic [7:0]       timestamp_ctrl_q;
    logic [7:0]       ref_out_ctrl_q;
    logic [POS_W-1:0] sync_edge_position;

    function automatic logic hit(input acpc_req_s r, input logic [14:0] ofs);
        return r.wr && (r.addr == ofs);
    endfunction

    function automatic logic [1:0] decode_mode(input logic [7:0] code);
        if (code == MODE_HIGH_PERF) begin
            return PMODE_HIGH_PERF;
        end else if (code == MODE_LOW_POWER) begin
            return PMODE_LOW_POWER;
        end
        return PMODE_RESERVED;
    endfunction

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            clock_ctrl_q <= RST_CLOCK_CTRL;
        end else if (hit(req, OFS_CLOCK_CTRL)) begin
            clock_ctrl_q <= req.wdata;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            supply_noise_q <= RST_SUPPLY_NOISE;
        end else if (hit(req, OFS_SUPPLY_NOISE)) begin
            supply_noise_q <= req.wdata;
        end
    end

    // two byte lanes, low byte at the base offset
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            full_scale_q <= RST_FULL_SCALE;
        end else if (hit(req, OFS_FULL_SCALE)) begin
            full_scale_q[7:0] <= req.wdata;
        end else if (hit(req, OFS_FULL_SCALE + 15'h0001)) begin
            full_scale_q[15:8] <= req.wdata;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            power_mode_code_q <= RST_POWER_MODE;
        end else if (hit(req, OFS_POWER_MODE)) begin
            power_mode_code_q <= req.wdata;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            timestamp_ctrl_q <= RST_TIMESTAMP;
        end else if (hit(req, OFS_TIMESTAMP)) begin
            timestamp_ctrl_q <= req.wdata;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ref_out_ctrl_q <= RST_REF_OUT;
        end else if (hit(req, OFS_REF_OUT)) begin
            ref_out_ctrl_q <= req.wdata;
        end
    end

    // position is loaded only by the detector, never by a write
    acpc_sync_capture #(
        .POS_W (POS_W)
    ) u_capture (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .load    (sync_pos_valid),
        .pos_in  (sync_pos_in),
        .pos_q   (sync_edge_position)
    );

    // ************************************************************
    // read path
    // ************************************************************
    logic [7:0] rd_d;

    always_comb begin
        rd_d = 8'h00;
        case (req.addr)
            OFS_CLOCK_CTRL:             rd_d = clock_ctrl_q;
            OFS_SUPPLY_NOISE:           rd_d = supply_noise_q;
            OFS_SYNC_POS:               rd_d = sync_edge_position[7:0];
            OFS_SYNC_POS + 15'h0001:    rd_d = sync_edge_position[15:8];
            OFS_SYNC_POS + 15'h0002:    rd_d = sync_edge_position[23:16];
            OFS_FULL_SCALE:             rd_d = full_scale_q[7:0];
            OFS_FULL_SCALE + 15'h0001:  rd_d = full_scale_q[15:8];
            OFS_POWER_MODE:             rd_d = power_mode_code_q;
            OFS_TIMESTAMP:              rd_d = timestamp_ctrl_q;
            OFS_REF_OUT:                rd_d = ref_out_ctrl_q;
            default:                    rd_d = 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q  <= 8'h00;
            rvalid_q <= 1'b0;
        end else begin
            rdata_q  <= req.rd ? rd_d : rdata_q;
            rvalid_q <= req.rd;
        end
    end

    // ************************************************************
    // control outputs
    // ************************************************************
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= '0;
            ctrl_q.full_scale_adjust <= RST_FULL_SCALE;
            ctrl_q.power_mode <= PMODE_HIGH_PERF;
        end else begin
            ctrl_q.analog_rail_quiet_enable <= supply_noise_q[BIT_ANALOG_QUIET];
            ctrl_q.clock_rail_quiet_enable  <= supply_noise_q[BIT_CLOCK_QUIET];
            ctrl_q.sync_delay_select <= clock_ctrl_q[SYNC_SEL_HI:0];
            ctrl_q.full_scale_adjust <= full_scale_q;
            ctrl_q.fs_below_min <= full_scale_q < FS_RECOMMENDED_MIN;
            ctrl_q.power_mode <= decode_mode(power_mode_code_q);
            ctrl_q.timestamp_input_enable <= timestamp_ctrl_q[BIT_TS_ENABLE];
            ctrl_q.timestamp_pecl_mode <= timestamp_ctrl_q[BIT_TS_PECL];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ref_clock_output_q <= 1'b0;
        end else begin
            ref_clock_output_q <= ref_out_ctrl_q[BIT_REF_OUT_EN] & synth_q;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    a_pos_read_only: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !sync_pos_valid |=> sync_edge_position == $past(sync_edge_position))
        else $error("position changed without capture");

    a_pos_read_value: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (req.rd && req.addr == OFS_SYNC_POS) |=> rdata_q == $past(sync_edge_position[7:0]))
        else $error("position low byte read wrong");

    a_delay_select: assert property (@(posedge ref_clk) disable iff (!rst_n)
        hit(req, OFS_CLOCK_CTRL) |-> ##2 ctrl_q.sync_delay_select == $past(req.wdata[3:0], 2))
        else $error("delay select not applied");

    a_fs_write_back: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (hit(req, OFS_FULL_SCALE + 15'h0001) ##1 (req.rd && req.addr == OFS_FULL_SCALE + 15'h0001))
        |=> rdata_q == $past(req.wdata, 2))
        else $error("full scale high byte read back wrong");

    a_fs_low_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ##1 ctrl_q.fs_below_min == ($past(full_scale_q) < FS_RECOMMENDED_MIN))
        else $error("below minimum flag wrong");

    a_mode_decode: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (power_mode_code_q == MODE_LOW_POWER) [*2] |-> ctrl_q.power_mode == PMODE_LOW_POWER)
        else $error("low power mode not decoded");

    a_ts_enable: assert property (@(posedge ref_clk) disable iff (!rst_n)
        hit(req, OFS_TIMESTAMP) |-> ##2 ctrl_q.timestamp_input_enable == $past(req.wdata[0], 2))
        else $error("timestamp enable wrong");

    a_ts_pecl: assert property (@(posedge ref_clk) disable iff (!rst_n)
        hit(req, OFS_TIMESTAMP) |-> ##2 ctrl_q.timestamp_pecl_mode == $past(req.wdata[1], 2))
        else $error("timestamp pecl mode wrong");

    a_ref_out_gate: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ref_clock_output_q |-> $past(ref_out_ctrl_q[BIT_REF_OUT_EN]) && $past(synth_q))
        else $error("reference output on while gated off");

    a_ref_out_on: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $rose(rst_n) |-> ref_out_ctrl_q == RST_REF_OUT)
        else $error("reference enable not set after reset");

    a_rail_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n)
        hit(req, OFS_SUPPLY_NOISE) |-> ##2 (ctrl_q.analog_rail_quiet_enable
        == $past(req.wdata[2], 2)) && (ctrl_q.clock_rail_quiet_enable == $past(req.wdata[0], 2)))
        else $error("rail quiet enables wrong");

endmodule

/* File: tb/adc_clock_power_config_regs_tb_top.sv */
// self-checking bench for the clock, power and full-scale configuration register bank
`timescale 1ns/1ps
module adc_clock_power_config_regs_tb_top
    import acpc_pkg::*;
;
    // ************************************************************
    // signals
    // ************************************************************
    logic             ref_clk;
    logic             rst_b;
    acpc_req_s        req;
    logic             sync_pos_valid;
    logic [23:0]      sync_pos_in;
    logic             synth_enable;
    logic [7:0]       rdata_q;
    logic             rvalid_q;
    acpc_ctrl_s       ctrl_q;
    logic             ref_clock_output_q;
    int               fail_count;
    int               n_compared;
    int               seed;
    logic [7:0]       mdl [int];
    logic [14:0]      alist [11];

    acpc_regs #(.POS_W(24)) i_dut (
        .ref_clk            (ref_clk),
        .rst_b              (rst_b),
        .req                (req),
        .sync_pos_valid     (sync_pos_valid),
        .sync_pos_in        (sync_pos_in),
        .synth_enable       (synth_enable),
        .rdata_q            (rdata_q),
        .rvalid_q           (rvalid_q),
        .ctrl_q             (ctrl_q),
        .ref_clock_output_q (ref_clock_output_q)
    );

    always #10 ref_clk = ~ref_clk;

    // ************************************************************
    // compare and report
    // ************************************************************
    task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cmp1(input string what, input logic exp, input logic got);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic cmp_ctrl(input acpc_ctrl_s exp, input acpc_ctrl_s got);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch ctrl expected %h seen %h", exp, got);
        end
    endtask

    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ************************************************************
    // reference model
    // ************************************************************
    function automatic void model_reset();
        mdl.delete();
        mdl[OFS_CLOCK_CTRL]             = RST_CLOCK_CTRL;
        mdl[OFS_SUPPLY_NOISE]           = RST_SUPPLY_NOISE;
        mdl[OFS_SYNC_POS]               = RST_SYNC_POS[7:0];
        mdl[OFS_SYNC_POS + 15'h0001]    = RST_SYNC_POS[15:8];
        mdl[OFS_SYNC_POS + 15'h0002]    = RST_SYNC_POS[23:16];
        mdl[OFS_FULL_SCALE]             = RST_FULL_SCALE[7:0];
        mdl[OFS_FULL_SCALE + 15'h0001]  = RST_FULL_SCALE[15:8];
        mdl[OFS_POWER_MODE]             = RST_POWER_MODE;
        mdl[OFS_TIMESTAMP]              = RST_TIMESTAMP;
        mdl[OFS_REF_OUT]                = RST_REF_OUT;
    endfunction

    function automatic acpc_ctrl_s exp_ctrl();
        acpc_ctrl_s  c;
        logic [15:0] fs;
        logic [7:0]  m;
        fs = {mdl[OFS_FULL_SCALE + 15'h0001], mdl[OFS_FULL_SCALE]};
        m  = mdl[OFS_POWER_MODE];
        c.analog_rail_quiet_enable = mdl[OFS_SUPPLY_NOISE][BIT_ANALOG_QUIET];
        c.clock_rail_quiet_enable  = mdl[OFS_SUPPLY_NOISE][BIT_CLOCK_QUIET];
        c.sync_delay_select        = mdl[OFS_CLOCK_CTRL][SYNC_SEL_HI:0];
        c.full_scale_adjust        = fs;
        c.power_mode = (m == MODE_HIGH_PERF) ? PMODE_HIGH_PERF :
                       (m == MODE_LOW_POWER) ? PMODE_LOW_POWER : PMODE_RESERVED;
        c.fs_below_min             = (fs < FS_RECOMMENDED_MIN);
        c.timestamp_input_enable   = mdl[OFS_TIMESTAMP][BIT_TS_ENABLE];
        c.timestamp_pecl_mode      = mdl[OFS_TIMESTAMP][BIT_TS_PECL];
        return c;
    endfunction

    // ************************************************************
    // register port and sequences
    // ************************************************************
    task automatic wr_reg(input logic [14:0] a, input logic [7:0] v);
        @(posedge ref_clk);
        req.wr    <= 1'b1;
        req.addr  <= a;
        req.wdata <= v;
        @(posedge ref_clk);
        req.wr    <= 1'b0;
        if (mdl.exists(a) && (a < OFS_SYNC_POS || a > OFS_SYNC_POS + 15'h0002)) begin
            mdl[a] = v;
        end
    endtask

    task automatic rd_reg(input logic [14:0] a, output logic [7:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        req.rd   <= 1'b1;
        req.addr <= a;
        @(posedge ref_clk);
        req.rd   <= 1'b0;
        #1;
        while (rvalid_q !== 1'b1 && n < 4) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        cmp1("rvalid", 1'b1, rvalid_q);
        d = rdata_q;
        @(posedge ref_clk);
        #1;
        cmp1("rvalid end", 1'b0, rvalid_q);
    endtask

    // write followed by a read of the same byte on the very next edge
    task automatic wr_rd(input logic [14:0] a, input logic [7:0] v, output logic [7:0] d);
        @(posedge ref_clk);
        req.wr    <= 1'b1;
        req.addr  <= a;
        req.wdata <= v;
        @(posedge ref_clk);
        req.wr    <= 1'b0;
        req.rd    <= 1'b1;
        mdl[a] = v;
        @(posedge ref_clk);
        req.rd    <= 1'b0;
        #1;
        cmp1("rvalid after write", 1'b1, rvalid_q);
        d = rdata_q;
    endtask

    task automatic check_all();
        logic [7:0] d;
        logic [7:0] e;
        for (int i = 0; i < 11; i++) begin
            rd_reg(alist[i], d);
            e = mdl.exists(alist[i]) ? mdl[alist[i]] : 8'h00;
            cmp8($sformatf("reg %h", alist[i]), e, d);
        end
        repeat (6) @(posedge ref_clk);
        #1;
        cmp_ctrl(exp_ctrl(), ctrl_q);
        cmp1("ref out", mdl[OFS_REF_OUT][0] & synth_enable, ref_clock_output_q);
    endtask

    task automatic do_reset();
        @(posedge ref_clk);
        rst_b <= 1'b0;
        repeat (10) @(posedge ref_clk);
        #1;
        cmp1("ref out in reset", 1'b0, ref_clock_output_q);
        @(posedge ref_clk);
        rst_b <= 1'b1;
        model_reset();
        repeat (3) @(posedge ref_clk);
    endtask

    // ************************************************************
    // main sequence and watchdog
    // ************************************************************
    initial begin
        logic [14:0] a;
        logic [7:0]  v;
        logic [23:0] p;
        logic [15:0] fs_tab [3];
        ref_clk        = 1'b0;
        rst_b          = 1'b0;
        req            = '0;
        sync_pos_valid = 1'b0;
        sync_pos_in    = 24'h000000;
        synth_enable   = 1'b1;
        fail_count     = 0;
        n_compared     = 0;
        seed           = 32'h02F3CBFD;
        alist  = '{15'h0029, 15'h002B, 15'h002C, 15'h002D, 15'h002E, 15'h0030,
                   15'h0031, 15'h0037, 15'h003B, 15'h003C, 15'h0040};
        fs_tab = '{16'h2000, 16'h1FFF, 16'hFFFF};
        do_reset();
        check_all();
        for (int k = 0; k < 60; k++) begin
            a = alist[{$random(seed)} % 11];
            v = 8'($random(seed));
            if (a == OFS_POWER_MODE && k % 3 != 2) begin
                v = (k % 3 == 0) ? MODE_LOW_POWER : MODE_HIGH_PERF;
            end
            // reserved fields always carry their defaults
            case (a)
                OFS_CLOCK_CTRL:   v = {RST_CLOCK_CTRL[7], v[6:0]};
                OFS_SUPPLY_NOISE: v = {RST_SUPPLY_NOISE[7:3], v[2], RST_SUPPLY_NOISE[1], v[0]};
                OFS_TIMESTAMP:    v = {RST_TIMESTAMP[7:2], v[1:0]};
                OFS_REF_OUT:      v = {RST_REF_OUT[7:1], v[0]};
                default:          v = v;
            endcase
            @(posedge ref_clk);
            synth_enable <= 1'($random(seed));
            if (k % 4 == 1) begin
                p = 24'($random(seed));
                sync_pos_valid <= 1'b1;
                sync_pos_in    <= p;
                @(posedge ref_clk);
                sync_pos_valid <= 1'b0;
                mdl[OFS_SYNC_POS]            = p[7:0];
                mdl[OFS_SYNC_POS + 15'h0001] = p[15:8];
                mdl[OFS_SYNC_POS + 15'h0002] = p[23:16];
                // delay select picked from the captured position
                wr_reg(OFS_CLOCK_CTRL, {RST_CLOCK_CTRL[7:4], p[3:0]});
            end
            wr_reg(a, v);
            check_all();
        end
        for (int j = 0; j < 3; j++) begin
            wr_reg(OFS_FULL_SCALE, fs_tab[j][7:0]);
            wr_rd(OFS_FULL_SCALE + 15'h0001, fs_tab[j][15:8], v);
            cmp8("full scale high", fs_tab[j][15:8], v);
            check_all();
        end
        do_reset();
        check_all();
        conclude();
    end

    initial begin
        #(20 * 40000);
        fail_count++;
        conclude();
    end
endmodule
